/* File: hw/irtp_top.sv */
`timescale 1ns/1ps
`include "irtp_defs.svh"
module irtp_top (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_N,
  // stop-mode recovery pulse
  input wire logic STOP_RECOVER,
  // register bank access
  input wire irtp_pkg::irtp_addr_t REG_ADDR,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire irtp_pkg::irtp_byte_t REG_WDATA,
  output logic [7:0] REG_RDATA,
  // sixteen-bit counter control held outside
  input wire logic WIDE_ENABLE,
  input wire logic [1:0] WIDE_CLK_SEL,
  // port output latches
  input wire logic PORT_A_DATA,
  input wire logic PORT_C_DATA,
  // pins
  input wire logic COMPARATOR_INPUT_PIN,
  input wire logic PORT_TWO_INPUT_PIN,
  output logic COUNTER_PIN_A,
  output logic COMBINED_OUTPUT_PIN,
  output logic EIGHT_BIT_COUNTER_OUTPUT,
  output logic SIXTEEN_BIT_COUNTER_OUTPUT,
  // requests
  output logic TIMEOUT_IRQ,
  output logic CAPTURE_IRQ,
  output logic WIDE_TIMEOUT
);
  import irtp_pkg::*;
  irtp_if cif ();
  irtp_prescale #(.CHANNELS(2)) u_pre (.clk(CORE_CLK), .rst_n(RST_N), .bus(cif));
  irtp_edge u_edge
  (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .cmp_pin(COMPARATOR_INPUT_PIN),
    .p2_pin(PORT_TWO_INPUT_PIN),
    .bus(cif)
  );
  // eight-bit control fields
  logic en8;
  logic oneshot8;
  logic tout8;
  logic [1:0] clk8;
  logic capie;
  logic tcie;
  logic pina;
  // shared control fields
  logic mode;
  logic pinsel;
  logic [1:0] fn;
  logic [1:0] sub;
  logic lvl8;
  logic lvl16;
  // data registers
  irtp_byte_t low_hold;
  irtp_byte_t high_hold;
  irtp_byte_t whold_lo;
  irtp_byte_t whold_hi;
  irtp_byte_t low_cap;
  irtp_byte_t high_cap;
  irtp_byte_t wcap_lo;
  irtp_byte_t wcap_hi;
  // counter state
  logic [7:0] cnt8;
  logic [15:0] cnt16;
  logic out8;
  logic out16;
  logic en8_d;
  logic en16_d;
  irtp_phase_t phase;
  logic [7:0] next_cnt8;
  logic [15:0] next_cnt16;
  logic next_out8;
  logic next_out16;
  logic [7:0] rd_mux;

  assign cif.clk_sel = {WIDE_CLK_SEL, clk8};
  assign cif.demod_en = mode;
  assign cif.in_sel = pinsel;
  assign cif.edge_sel = fn;
  assign cif.filt_sel = sub;

  // decode
  wire wr_c8 = REG_WR && REG_ADDR == `IRTP_A_CTRL8;
  wire wr_sh = REG_WR && REG_ADDR == `IRTP_A_SHARED;
  wire demod = mode;
  wire alt = !demod && sub == `IRTP_SUB_ALT;
  wire run8 = en8 && (!alt || phase == IRTP_PH_EIGHT);
  wire run16 = WIDE_ENABLE && (!alt || phase == IRTP_PH_WIDE);
  wire start8 = en8 && !en8_d;
  wire start16 = WIDE_ENABLE && !en16_d;
  wire tick8 = cif.tick[0];
  wire tick16 = cif.tick[1];
  wire at_end8 = demod ? cnt8 == `IRTP_MAX8 : cnt8 == `IRTP_RST_BYTE;
  wire at_end16 = demod ? cnt16 == `IRTP_MAX16 : cnt16 == `IRTP_RST_WORD;
  wire tc8 = run8 && tick8 && !start8 && at_end8;
  wire tc16 = run16 && tick16 && !start16 && at_end16;
  wire cap = demod && (cif.pos_edge || cif.neg_edge);
  wire cap8 = cap && en8;
  wire cap16 = cap && WIDE_ENABLE;
  wire stop8 = tc8 && oneshot8;
  wire [15:0] whold = {whold_hi, whold_lo};
  wire clr_tout = wr_c8 && REG_WDATA[`IRTP_C8_TOUT];
  wire clr_rise = wr_sh && REG_WDATA[`IRTP_SH_LVL8];
  wire clr_fall = wr_sh && REG_WDATA[`IRTP_SH_LVL16];
  // the forced levels act at once, bypassing the counter
  wire out16_eff = (!demod && sub == `IRTP_SUB_FORCE0) ? 1'b0 :
                   (!demod && sub == `IRTP_SUB_FORCE1) ? 1'b1 : out16;
  wire comb_and = out8 && out16_eff;
  wire comb_or = out8 || out16_eff;
  wire combined = (fn == `IRTP_FN_AND) ? comb_and :
                  (fn == `IRTP_FN_OR) ? comb_or :
                  (fn == `IRTP_FN_NOR) ? !comb_or : !comb_and;
  wire next_en8 = STOP_RECOVER ? 1'b0 :
                  wr_c8 ? REG_WDATA[`IRTP_C8_EN] : (en8 && !stop8);
  wire next_lvl8 = demod ? (cif.pos_edge || (lvl8 && !clr_rise)) :
                   (wr_sh ? REG_WDATA[`IRTP_SH_LVL8] : lvl8);
  wire next_lvl16 = demod ? (cif.neg_edge || (lvl16 && !clr_fall)) :
                    (wr_sh ? REG_WDATA[`IRTP_SH_LVL16] : lvl16);

  // eight-bit counter: counts down between holds in transmit, up in demodulation
  always_comb
  begin
    next_cnt8 = cnt8;
    next_out8 = out8;
    if (start8)
    begin
      next_cnt8 = demod ? `IRTP_RST_BYTE : (lvl8 ? high_hold : low_hold);
      next_out8 = demod ? out8 : lvl8;
    end
    else if (!en8)
      next_out8 = demod ? out8 : !lvl8;
    else if (demod)
    begin
      if (cap8)
        next_cnt8 = `IRTP_RST_BYTE;
      else if (run8 && tick8)
        next_cnt8 = cnt8 + 8'h01;
    end
    else if (tc8)
    begin
      next_out8 = !out8;
      next_cnt8 = out8 ? low_hold : high_hold;
    end
    else if (run8 && tick8)
      next_cnt8 = cnt8 - 8'h01;
  end

  // sixteen-bit counter: modulo reload from the wide hold
  always_comb
  begin
    next_cnt16 = cnt16;
    next_out16 = out16;
    if (start16)
    begin
      next_cnt16 = demod ? `IRTP_RST_WORD : whold;
      next_out16 = demod ? out16 : lvl16;
    end
    else if (!WIDE_ENABLE)
      next_out16 = demod ? out16 : !lvl16;
    else if (demod)
    begin
      if (cap16)
        next_cnt16 = `IRTP_RST_WORD;
      else if (run16 && tick16)
        next_cnt16 = cnt16 + 16'h0001;
    end
    else if (tc16)
    begin
      next_out16 = !out16;
      next_cnt16 = whold;
    end
    else if (run16 && tick16)
      next_cnt16 = cnt16 - 16'h0001;
  end

  // fields marked for survival keep their value on stop recovery
  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      tout8 <= 1'b0;
      clk8 <= `IRTP_RST_SEL;
      capie <= 1'b0;
      tcie <= 1'b0;
      fn <= `IRTP_RST_SEL;
    end
    else
    begin
      tout8 <= tc8 || (tout8 && !clr_tout);
      clk8 <= wr_c8 ? REG_WDATA[`IRTP_C8_CLK_HI:`IRTP_C8_CLK_LO] : clk8;
      capie <= wr_c8 ? REG_WDATA[`IRTP_C8_CAPIE] : capie;
      tcie <= wr_c8 ? REG_WDATA[`IRTP_C8_TCIE] : tcie;
      fn <= wr_sh ? REG_WDATA[`IRTP_SH_FN_HI:`IRTP_SH_FN_LO] : fn;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      en8 <= 1'b0;
      oneshot8 <= 1'b0;
      pina <= 1'b0;
      mode <= 1'b0;
      pinsel <= 1'b0;
      sub <= `IRTP_SUB_NORMAL;
      lvl8 <= 1'b0;
      lvl16 <= 1'b0;
    end
    else if (STOP_RECOVER)
    begin
      en8 <= 1'b0;
      oneshot8 <= 1'b0;
      pina <= 1'b0;
      mode <= 1'b0;
      pinsel <= 1'b0;
      sub <= `IRTP_SUB_NORMAL;
      lvl8 <= 1'b0;
      lvl16 <= 1'b0;
    end
    else
    begin
      en8 <= next_en8;
      oneshot8 <= wr_c8 ? REG_WDATA[`IRTP_C8_ONESHOT] : oneshot8;
      pina <= wr_c8 ? REG_WDATA[`IRTP_C8_PINA] : pina;
      mode <= wr_sh ? REG_WDATA[`IRTP_SH_MODE] : mode;
      pinsel <= wr_sh ? REG_WDATA[`IRTP_SH_PINSEL] : pinsel;
      sub <= wr_sh ? REG_WDATA[`IRTP_SH_SUB_HI:`IRTP_SH_SUB_LO] : sub;
      lvl8 <= next_lvl8;
      lvl16 <= next_lvl16;
    end
  end

  // hold registers
  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      low_hold <= `IRTP_RST_BYTE;
      high_hold <= `IRTP_RST_BYTE;
      whold_lo <= `IRTP_RST_BYTE;
      whold_hi <= `IRTP_RST_BYTE;
    end
    else if (REG_WR)
    begin
      low_hold <= (REG_ADDR == `IRTP_A_LOW_HOLD) ? REG_WDATA : low_hold;
      high_hold <= (REG_ADDR == `IRTP_A_HIGH_HOLD) ? REG_WDATA : high_hold;
      whold_lo <= (REG_ADDR == `IRTP_A_WHOLD_LO) ? REG_WDATA : whold_lo;
      whold_hi <= (REG_ADDR == `IRTP_A_WHOLD_HI) ? REG_WDATA : whold_hi;
    end
  end

  // captures: a rising edge ends a low phase, a falling edge a high one
  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      low_cap <= `IRTP_RST_BYTE;
      high_cap <= `IRTP_RST_BYTE;
      wcap_lo <= `IRTP_RST_BYTE;
      wcap_hi <= `IRTP_RST_BYTE;
    end
    else
    begin
      low_cap <= (cap8 && cif.pos_edge) ? cnt8 : low_cap;
      high_cap <= (cap8 && cif.neg_edge) ? cnt8 : high_cap;
      wcap_lo <= cap16 ? cnt16[7:0] : wcap_lo;
      wcap_hi <= cap16 ? cnt16[15:8] : wcap_hi;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      cnt8 <= `IRTP_RST_BYTE;
      cnt16 <= `IRTP_RST_WORD;
      out8 <= 1'b1;
      out16 <= 1'b1;
      en8_d <= 1'b0;
      en16_d <= 1'b0;
      phase <= IRTP_PH_EIGHT;
    end
    else
    begin
      cnt8 <= next_cnt8;
      cnt16 <= next_cnt16;
      out8 <= next_out8;
      out16 <= next_out16;
      en8_d <= en8;
      en16_d <= WIDE_ENABLE;
      // alternating hands the turn over at each terminal count
      phase <= !alt ? IRTP_PH_EIGHT :
               tc8 ? IRTP_PH_WIDE :
               tc16 ? IRTP_PH_EIGHT : phase;
    end
  end

  // read mux: capture and flag reads have no side effect
  always_comb
  begin
    unique case (REG_ADDR)
      `IRTP_A_CTRL8: rd_mux = {en8, oneshot8, tout8, clk8, capie, tcie, pina};
      `IRTP_A_SHARED: rd_mux = {mode, pinsel, fn, sub, lvl8, lvl16};
      `IRTP_A_LOW_HOLD: rd_mux = low_hold;
      `IRTP_A_HIGH_HOLD: rd_mux = high_hold;
      `IRTP_A_WHOLD_LO: rd_mux = whold_lo;
      `IRTP_A_WHOLD_HI: rd_mux = whold_hi;
      `IRTP_A_WCAP_LO: rd_mux = wcap_lo;
      `IRTP_A_WCAP_HI: rd_mux = wcap_hi;
      `IRTP_A_LOW_CAP: rd_mux = low_cap;
      `IRTP_A_HIGH_CAP: rd_mux = high_cap;
      default: rd_mux = `IRTP_RST_BYTE;
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      REG_RDATA <= `IRTP_RST_BYTE;
      COUNTER_PIN_A <= 1'b0;
      COMBINED_OUTPUT_PIN <= 1'b0;
      SIXTEEN_BIT_COUNTER_OUTPUT <= 1'b0;
      TIMEOUT_IRQ <= 1'b0;
      CAPTURE_IRQ <= 1'b0;
      WIDE_TIMEOUT <= 1'b0;
    end
    else
    begin
      REG_RDATA <= REG_RD ? rd_mux : REG_RDATA;
      COUNTER_PIN_A <= pina ? out8 : PORT_A_DATA;
      COMBINED_OUTPUT_PIN <= (!demod && pinsel) ? combined : PORT_C_DATA;
      SIXTEEN_BIT_COUNTER_OUTPUT <= out16_eff;
      TIMEOUT_IRQ <= tc8 && tcie;
      CAPTURE_IRQ <= cap8 && capie;
      WIDE_TIMEOUT <= tc16;
    end
  end
  assign EIGHT_BIT_COUNTER_OUTPUT = out8;

  AST_ENABLE_WRITE: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (wr_c8 && !STOP_RECOVER) |=> en8 == $past(REG_WDATA[`IRTP_C8_EN]))
  else $error("enable does not follow write");
  AST_ONESHOT_STOP: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (tc8 && oneshot8 && !wr_c8) |=> !en8)
  else $error("one-shot counter kept running");
  AST_FLAG_STICKY: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (tc8 || (tout8 && !clr_tout)) |=> tout8)
  else $error("terminal flag lost");
  AST_CAPTURE_REQ: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    CAPTURE_IRQ == ($past(cap8) && $past(capie)))
  else $error("capture request mismatch");
  AST_TIMEOUT_REQ: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (tc8 && tcie) |=> TIMEOUT_IRQ ##1 (!TIMEOUT_IRQ || $past(tc8)))
  else $error("terminal request mismatch");
  AST_PIN_A_PORT: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    !pina |=> COUNTER_PIN_A == $past(PORT_A_DATA))
  else $error("pin A not showing port latch");
  AST_RECOVER_KEEP: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (STOP_RECOVER && !REG_WR) |=> !en8 && clk8 == $past(clk8) && tcie == $past(tcie))
  else $error("stop recovery touched kept fields");
  AST_IDLE_LEVEL: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (!demod && !en8) |=> out8 != $past(lvl8))
  else $error("idle output not opposite of start level");
  AST_START_LEVEL: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (!demod && start16) |=> out16 == $past(lvl16))
  else $error("wide output start level wrong");
  AST_RISE_FLAG: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (demod && cif.pos_edge && !STOP_RECOVER) |=> lvl8)
  else $error("rising flag not set");
  AST_FORCE_HIGH: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (!demod && sub == `IRTP_SUB_FORCE1) |=> SIXTEEN_BIT_COUNTER_OUTPUT)
  else $error("forced wide output not high");
endmodule

/* File: hw/irtp_defs.svh */
`ifndef IRTP_DEFS_SVH
`define IRTP_DEFS_SVH

// register bank offsets
`define IRTP_A_CTRL8 4'h0
`define IRTP_A_SHARED 4'h1
`define IRTP_A_LOW_HOLD 4'h4
`define IRTP_A_HIGH_HOLD 4'h5
`define IRTP_A_WHOLD_LO 4'h6
`define IRTP_A_WHOLD_HI 4'h7
`define IRTP_A_WCAP_LO 4'h8
`define IRTP_A_WCAP_HI 4'h9
`define IRTP_A_LOW_CAP 4'ha
`define IRTP_A_HIGH_CAP 4'hb

// eight-bit counter control fields
`define IRTP_C8_EN 7
`define IRTP_C8_ONESHOT 6
`define IRTP_C8_TOUT 5
`define IRTP_C8_CLK_HI 4
`define IRTP_C8_CLK_LO 3
`define IRTP_C8_CAPIE 2
`define IRTP_C8_TCIE 1
`define IRTP_C8_PINA 0

// shared control fields
`define IRTP_SH_MODE 7
`define IRTP_SH_PINSEL 6
`define IRTP_SH_FN_HI 5
`define IRTP_SH_FN_LO 4
`define IRTP_SH_SUB_HI 3
`define IRTP_SH_SUB_LO 2
`define IRTP_SH_LVL8 1
`define IRTP_SH_LVL16 0

// reset and limit values
`define IRTP_RST_BYTE 8'h00
`define IRTP_RST_WORD 16'h0000
`define IRTP_RST_SEL 2'h0
`define IRTP_MAX8 8'hff
`define IRTP_MAX16 16'hffff

// transmit submodes
`define IRTP_SUB_NORMAL 2'h0
`define IRTP_SUB_ALT 2'h1
`define IRTP_SUB_FORCE0 2'h2
`define IRTP_SUB_FORCE1 2'h3

// output combining functions
`define IRTP_FN_AND 2'h0
`define IRTP_FN_OR 2'h1
`define IRTP_FN_NOR 2'h2
`define IRTP_FN_NAND 2'h3

// edge select and glitch filter codes
`define IRTP_EDGE_FALL 2'h0
`define IRTP_EDGE_RISE 2'h1
`define IRTP_EDGE_BOTH 2'h2
`define IRTP_FILT_4 2'h1
`define IRTP_FILT_8 2'h2
`define IRTP_FILT4_CYC 4'h4
`define IRTP_FILT8_CYC 4'h8
`define IRTP_FILT_NONE_CYC 4'h0

`endif

/* File: hw/irtp_pkg.sv */
package irtp_pkg;
  typedef logic [7:0] irtp_byte_t;
  typedef logic [3:0] irtp_addr_t;
  typedef enum logic [1:0]
  {
    IRTP_PH_EIGHT = 2'b01,
    IRTP_PH_WIDE = 2'b10
  } irtp_phase_t;
endpackage

/* File: hw/irtp_if.sv */
`timescale 1ns/1ps
interface irtp_if;
  logic [3:0] clk_sel;
  logic [1:0] tick;
  logic demod_en;
  logic in_sel;
  logic [1:0] edge_sel;
  logic [1:0] filt_sel;
  logic pos_edge;
  logic neg_edge;
  logic level;
  modport pre_mp
  (
    input clk_sel,
    output tick
  );
  modport edge_mp
  (
    input demod_en, in_sel, edge_sel, filt_sel,
    output pos_edge, neg_edge, level
  );
  modport core_mp
  (
    output clk_sel, demod_en, in_sel, edge_sel, filt_sel,
    input tick, pos_edge, neg_edge, level
  );
endinterface

/* File: hw/irtp_prescale.sv */
`timescale 1ns/1ps
module irtp_prescale #(
  parameter int CHANNELS = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // selects and enables
  irtp_if.pre_mp bus
);
  import irtp_pkg::*;
  logic [2:0] div;
  // one free divider shared by all channels keeps ticks phase aligned
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      div <= 3'h0;
    else
      div <= div + 3'h1;
  end
  genvar i;
  generate
    for (i = 0; i < CHANNELS; i = i + 1)
    begin : g_ch
      wire [1:0] sel = bus.clk_sel[2*i+1:2*i];
      wire [2:0] mask = {sel == 2'h3, sel[1], sel != 2'h0};
      assign bus.tick[i] = (div & mask) == mask;
      AST_DIV2_SPACING: assert property (@(posedge clk) disable iff (!rst_n)
        (sel == 2'h1 && bus.tick[i]) ##1 (sel == 2'h1) |->
        !bus.tick[i] ##1 (bus.tick[i] || sel != 2'h1))
      else $error("divide by two tick spacing wrong");
    end
  endgenerate
endmodule

/* File: hw/irtp_edge.sv */
`timescale 1ns/1ps
`include "irtp_defs.svh"
module irtp_edge (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // demodulation input pins
  input wire logic cmp_pin,
  input wire logic p2_pin,
  // edge results
  irtp_if.edge_mp bus
);
  import irtp_pkg::*;
  logic [1:0] sync1;
  logic [1:0] sync2;
  logic [3:0] cnt;
  logic level;
  logic pos_edge;
  logic neg_edge;
  wire raw = bus.in_sel ? sync2[1] : sync2[0];
  wire [3:0] need = (bus.filt_sel == `IRTP_FILT_4) ? `IRTP_FILT4_CYC :
                    (bus.filt_sel == `IRTP_FILT_8) ? `IRTP_FILT8_CYC :
                    `IRTP_FILT_NONE_CYC;
  wire differ = raw != level;
  wire accept = differ && (need == 4'h0 || cnt >= need - 4'h1);
  wire rise_ok = bus.edge_sel == `IRTP_EDGE_RISE || bus.edge_sel == `IRTP_EDGE_BOTH;
  wire fall_ok = bus.edge_sel == `IRTP_EDGE_FALL || bus.edge_sel == `IRTP_EDGE_BOTH;
  // both pins synchronised so switching the source never feeds a raw pin to logic
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1 <= 2'h0;
      sync2 <= 2'h0;
    end
    else
    begin
      sync1 <= {p2_pin, cmp_pin};
      sync2 <= sync1;
    end
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt <= 4'h0;
      level <= 1'b0;
      pos_edge <= 1'b0;
      neg_edge <= 1'b0;
    end
    else
    begin
      cnt <= (!differ || accept) ? 4'h0 : cnt + 4'h1;
      level <= accept ? raw : level;
      pos_edge <= bus.demod_en && accept && raw && rise_ok;
      neg_edge <= bus.demod_en && accept && !raw && fall_ok;
    end
  end
  assign bus.level = level;
  assign bus.pos_edge = pos_edge;
  assign bus.neg_edge = neg_edge;
  AST_EDGE_SELECT: assert property (@(posedge clk) disable iff (!rst_n)
    bus.pos_edge |-> $past(rise_ok) && level)
  else $error("rising edge reported while not selected");
endmodule

/* File: testbench/irtp_pin_model.sv */
`timescale 1ns/1ps
// far-side pins; comparator held low until a scenario hands the input to it
module irtp_pin_model (
  // clock
  input wire logic clk,
  // pins
  output logic cmp_pin,
  output logic p2_pin
);
  initial
  begin
    cmp_pin = 1'b0;
    p2_pin = 1'b0;
  end
  // short pulses exercise the glitch filter
  task automatic pulse(input int n, input logic v);
    @(posedge clk);
    p2_pin <= v;
    repeat (n) @(posedge clk);
    p2_pin <= ~v;
  endtask
  task automatic level(input logic v);
    @(posedge clk);
    p2_pin <= v;
  endtask
  task automatic cmp_level(input logic v);
    @(posedge clk);
    cmp_pin <= v;
  endtask
endmodule

/* File: testbench/irtp_top_tb.sv */
`timescale 1ns/1ps
`include "irtp_defs.svh"
module irtp_top_tb;
  import irtp_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic stop_rec = 1'b0;
  irtp_addr_t addr = 4'h0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  irtp_byte_t wdata = 8'h00;
  logic [7:0] rdata;
  logic port_a = 1'b0;
  logic port_c = 1'b1;
  logic wide_en = 1'b0;
  logic [1:0] wide_sel = 2'h0;
  logic pin_a, comb, out8, out16, tmo_irq, cap_irq, cmp_pin, p2_pin, wide_tmo;
  int error_cnt = 0;
  int compares = 0;
  always #12.5 clk = ~clk;
  irtp_top i_irtp_top (
    .CORE_CLK(clk), .RST_N(rst_n), .STOP_RECOVER(stop_rec),
    .REG_ADDR(addr), .REG_WR(wr_en), .REG_RD(rd_en), .REG_WDATA(wdata), .REG_RDATA(rdata),
    .WIDE_ENABLE(wide_en), .WIDE_CLK_SEL(wide_sel), .PORT_A_DATA(port_a), .PORT_C_DATA(port_c),
    .COMPARATOR_INPUT_PIN(cmp_pin), .PORT_TWO_INPUT_PIN(p2_pin), .COUNTER_PIN_A(pin_a),
    .COMBINED_OUTPUT_PIN(comb), .EIGHT_BIT_COUNTER_OUTPUT(out8),
    .SIXTEEN_BIT_COUNTER_OUTPUT(out16), .TIMEOUT_IRQ(tmo_irq), .CAPTURE_IRQ(cap_irq),
    .WIDE_TIMEOUT(wide_tmo)
  );
  irtp_pin_model i_irtp_pin_model (.clk(clk), .cmp_pin(cmp_pin), .p2_pin(p2_pin));
  task automatic finish_test();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic rchk(input string nm, input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    chk(nm, e, rdata);
  endtask
  // bounded wait for a one-cycle request pulse
  task automatic wait_irq(input int src, output int n);
    n = 0;
    // settle first: callers often arrive in the time step of the launching edge
    #1;
    while ((((src == 2) ? wide_tmo : (src == 1) ? cap_irq : tmo_irq) !== 1'b1) && n < 400)
    begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask
  task automatic t_reset();
    rchk("ctl8", `IRTP_A_CTRL8, 8'h00);
    rchk("shared", `IRTP_A_SHARED, 8'h00);
    chk("out8", 8'h01, {7'h00, out8});
    $display("test reset done");
  endtask
  task automatic t_regs();
    for (int i = 4; i < 8; i++)
    begin
      wr(i[3:0], 8'h5a + i[7:0]);
      rchk("hold", i[3:0], 8'h5a + i[7:0]);
    end
    for (int i = 8; i < 13; i++)
    begin
      wr(i[3:0], 8'hff);
      rchk("cap_ro", i[3:0], 8'h00);
    end
    $display("test regs done");
  endtask
  task automatic t_oneshot();
    int n;
    wr(`IRTP_A_LOW_HOLD, 8'h02);
    wr(`IRTP_A_CTRL8, 8'hc3);
    wait_irq(1'b0, n);
    chk("tmo_irq", 8'h01, {7'h00, tmo_irq});
    rchk("ctl8", `IRTP_A_CTRL8, 8'h63);
    chk("pin_a", 8'h01, {7'h00, pin_a});
    wr(`IRTP_A_CTRL8, 8'h43);
    rchk("ctl8", `IRTP_A_CTRL8, 8'h63);
    wr(`IRTP_A_CTRL8, 8'h62);
    rchk("ctl8", `IRTP_A_CTRL8, 8'h42);
    chk("pin_a", 8'h00, {7'h00, pin_a});
    // modulo mode must time out twice while staying enabled
    wr(`IRTP_A_CTRL8, 8'h82);
    wait_irq(1'b0, n);
    @(posedge clk);
    wait_irq(1'b0, n);
    chk("second", 8'h01, {7'h00, tmo_irq});
    rchk("ctl8", `IRTP_A_CTRL8, 8'ha2);
    wr(`IRTP_A_CTRL8, 8'h20);
    rchk("ctl8", `IRTP_A_CTRL8, 8'h00);
    $display("test oneshot done");
  endtask
  task automatic t_clksel();
    int n;
    int dv;
    wr(`IRTP_A_LOW_HOLD, 8'h03);
    for (int s = 0; s < 4; s++)
    begin
      dv = 1 << s;
      wr(`IRTP_A_CTRL8, {3'b110, s[1:0], 3'b010});
      wait_irq(1'b0, n);
      chk("span", 8'h01, {7'h00, (n >= 3 * dv + 1) && (n <= 4 * dv + 8)});
      wr(`IRTP_A_CTRL8, 8'h20);
    end
    $display("test clksel done");
  endtask
  task automatic t_combine();
    logic e;
    wr(`IRTP_A_CTRL8, 8'h00);
    for (int i = 0; i < 8; i++)
    begin
      wr(`IRTP_A_SHARED, {2'b01, i[2:1], 1'b1, i[0], 2'b00});
      repeat (4) @(posedge clk);
      #1;
      case (i[2:1])
        2'h0: e = i[0];
        2'h1: e = 1'b1;
        2'h2: e = 1'b0;
        default: e = ~i[0];
      endcase
      chk("comb", {7'h00, e}, {7'h00, comb});
      chk("out16", {7'h00, i[0]}, {7'h00, out16});
      chk("out8", 8'h01, {7'h00, out8});
    end
    wr(`IRTP_A_SHARED, 8'h03);
    repeat (4) @(posedge clk);
    #1;
    chk("out8", 8'h00, {7'h00, out8});
    chk("out16", 8'h00, {7'h00, out16});
    chk("comb", 8'h01, {7'h00, comb});
    $display("test combine done");
  endtask
  task automatic t_wide();
    int n;
    int hits;
    wr(`IRTP_A_WHOLD_LO, 8'h03);
    wr(`IRTP_A_WHOLD_HI, 8'h00);
    wr(`IRTP_A_SHARED, 8'h01);
    @(posedge clk);
    wide_en <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk("out16_start", 8'h01, {7'h00, out16});
    wait_irq(2, n);
    chk("wide_tmo", 8'h01, {7'h00, wide_tmo});
    @(posedge clk);
    #1;
    chk("out16_toggle", 8'h00, {7'h00, out16});
    // alternating with the eight-bit counter idle: the wide turn never comes
    wr(`IRTP_A_SHARED, 8'h05);
    repeat (2) @(posedge clk);
    hits = 0;
    repeat (20)
    begin
      @(posedge clk);
      #1;
      hits += (wide_tmo === 1'b1);
    end
    chk("alt_hold", 8'h00, hits[7:0]);
    wr(`IRTP_A_SHARED, 8'h01);
    @(posedge clk);
    wide_sel <= 2'h3;
    @(posedge clk);
    wait_irq(2, n);
    @(posedge clk);
    wait_irq(2, n);
    // four divide-by-eight ticks per reload of three, less the edge skipped
    chk("wide_span", 8'h1f, n[7:0]);
    @(posedge clk);
    wide_en <= 1'b0;
    wide_sel <= 2'h0;
    $display("test wide done");
  endtask
  task automatic t_stop();
    wr(`IRTP_A_LOW_HOLD, 8'hff);
    wr(`IRTP_A_CTRL8, 8'hdf);
    wr(`IRTP_A_SHARED, 8'h7c);
    @(posedge clk);
    stop_rec <= 1'b1;
    @(posedge clk);
    stop_rec <= 1'b0;
    rchk("ctl8", `IRTP_A_CTRL8, 8'h1e);
    rchk("shared", `IRTP_A_SHARED, 8'h30);
    $display("test stop done");
  endtask
  task automatic t_demod();
    int n;
    // port two input keeps the comparator path out of it
    wr(`IRTP_A_SHARED, 8'hc0);
    wr(`IRTP_A_CTRL8, 8'h84);
    i_irtp_pin_model.level(1'b1);
    repeat (20) @(posedge clk);
    rchk("fall_only", `IRTP_A_SHARED, 8'hc0);
    i_irtp_pin_model.level(1'b0);
    wait_irq(1'b1, n);
    rchk("fall", `IRTP_A_SHARED, 8'hc1);
    wr(`IRTP_A_SHARED, 8'he5);
    rchk("clear", `IRTP_A_SHARED, 8'he4);
    i_irtp_pin_model.pulse(2, 1'b1);
    repeat (20) @(posedge clk);
    rchk("glitch", `IRTP_A_SHARED, 8'he4);
    i_irtp_pin_model.level(1'b1);
    wait_irq(1'b1, n);
    chk("cap_irq", 8'h01, {7'h00, cap_irq});
    rchk("rise", `IRTP_A_SHARED, 8'he6);
    wr(`IRTP_A_SHARED, 8'he4);
    rchk("keep", `IRTP_A_SHARED, 8'he6);
    wr(`IRTP_A_SHARED, 8'he6);
    rchk("clear", `IRTP_A_SHARED, 8'he4);
    // drop port two, then hand the input to the comparator pin
    i_irtp_pin_model.level(1'b0);
    repeat (20) @(posedge clk);
    wr(`IRTP_A_SHARED, 8'ha1);
    rchk("cmp_sel", `IRTP_A_SHARED, 8'ha0);
    i_irtp_pin_model.level(1'b1);
    repeat (20) @(posedge clk);
    rchk("p2_off", `IRTP_A_SHARED, 8'ha0);
    i_irtp_pin_model.cmp_level(1'b1);
    wait_irq(1'b1, n);
    rchk("cmp_rise", `IRTP_A_SHARED, 8'ha2);
    $display("test demod done");
  endtask
  initial
  begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_regs();
    t_oneshot();
    t_clksel();
    t_combine();
    t_wide();
    t_stop();
    t_demod();
    finish_test();
  end
  // the whole sequence needs a few hundred cycles
  initial
  begin
    #1000000;
    error_cnt++;
    finish_test();
  end
endmodule
